// file: src/ppr_defines.svh
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH

// ----------------------------------------------------------------------
// frame characters
// ----------------------------------------------------------------------
`define PPR_CH_COLON 8'h3a
`define PPR_CH_CR 8'h0d
`define PPR_CH_LF 8'h0a

// ----------------------------------------------------------------------
// query and reply fields
// ----------------------------------------------------------------------
`define PPR_FUNC_READ 8'h03
`define PPR_REG_ALARM_PROG 16'h9023
`define PPR_REG_PRESS_STAT 16'h9024
`define PPR_REG_COUNT_ONE 16'h0001
`define PPR_BYTE_COUNT_ONE 8'h02
`define PPR_ADDR_OFFSET 8'h01
`define PPR_ALARM_IDLE 16'h0000

// ----------------------------------------------------------------------
// frame lengths
// ----------------------------------------------------------------------
`define PPR_QUERY_CHARS 5'd17
`define PPR_QUERY_HEX 4'd14
`define PPR_RESP_CHARS 4'd15
`define PPR_RESP_HEX 4'd12

`endif

// file: src/ppr_modbus_reader.sv
`timescale 1ns/1ps
// Function
// - the address field is the axis number plus one, 01 to 10, and only our own address is answered.
// - function 03 at start 9023 with count 0001 returns the alarm program number register.
// - the alarm program number reads 00 while no alarm is active, else the program that raised it.
// - function 03 at start 9024 with count 0001 returns the 16-bit press program status.
// - a one-register reply carries byte count 02 and then four hex characters, most significant first.
// - the query frame is 17 characters long and the reply frame 15.
// - every frame starts with a colon and ends with carriage return then line feed.
// - a two-character LRC field stands just before the trailer of every frame.
// - every binary byte travels as two ASCII hex characters.
module ppr_modbus_reader (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic [3:0] i_axis_number,
  input wire logic i_rx_valid,
  input wire ppr_pkg::ppr_char_t i_rx_char,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output ppr_pkg::ppr_char_t o_tx_char,
  input wire logic i_alarm_active,
  input wire ppr_pkg::ppr_reg_t i_alarm_program,
  input wire ppr_pkg::ppr_reg_t i_press_status,
  output logic o_reply_busy,
  output logic o_query_served,
  output logic o_query_dropped
);
  import ppr_pkg::*;
  `include "ppr_defines.svh"

  logic [3:0] axis_meta_ff;
  logic [3:0] axis_sync_ff;
  ppr_byte_t own_addr;

  ppr_rx_state_e state_ff;
  logic [3:0] nib_cnt_ff;
  logic [3:0] hi_nib_ff;
  logic [55:0] bytes_ff;
  ppr_byte_t sum_ff;
  logic [4:0] char_cnt_ff;
  logic served_ff;
  logic dropped_ff;
  ppr_reg_t value_ff;

  logic is_hex;
  logic [3:0] hex_val;
  ppr_byte_t new_byte;
  ppr_byte_t lrc_sum;
  ppr_byte_t f_addr;
  ppr_byte_t f_func;
  ppr_reg_t f_start;
  ppr_reg_t f_count;
  logic is_colon;
  logic frame_end;
  logic query_ok;
  logic tx_busy;

  // ----------------------------------------------------------------------
  // axis number synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      axis_meta_ff <= 4'h0;
      axis_sync_ff <= 4'h0;
    end else if (i_clk_en) begin
      axis_meta_ff <= i_axis_number;
      axis_sync_ff <= axis_meta_ff;
    end
  end

  assign own_addr = {4'h0, axis_sync_ff} + `PPR_ADDR_OFFSET;

  // ----------------------------------------------------------------------
  // query decode
  // ----------------------------------------------------------------------
  assign is_hex = ppr_hex_valid(i_rx_char);
  assign hex_val = ppr_hex_val(i_rx_char);
  assign new_byte = {hi_nib_ff, hex_val};
  assign f_addr = bytes_ff[55:48];
  assign f_func = bytes_ff[47:40];
  assign f_start = bytes_ff[39:24];
  assign f_count = bytes_ff[23:8];
  assign lrc_sum = sum_ff + bytes_ff[7:0];
  assign is_colon = i_rx_char == `PPR_CH_COLON;
  assign frame_end = i_rx_valid && state_ff == PPR_RX_LF &&
                     i_rx_char == `PPR_CH_LF;

  assign query_ok = f_addr == own_addr &&
                    f_func == `PPR_FUNC_READ &&
                    (f_start == `PPR_REG_ALARM_PROG ||
                     f_start == `PPR_REG_PRESS_STAT) &&
                    f_count == `PPR_REG_COUNT_ONE &&
                    lrc_sum == 8'h00 &&
                    char_cnt_ff == `PPR_QUERY_CHARS - 5'd1 &&
                    !tx_busy;

  // ----------------------------------------------------------------------
  // receive state
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= PPR_RX_IDLE;
    end else if (i_clk_en && i_rx_valid) begin
      if (is_colon) begin
        state_ff <= PPR_RX_HEX;
      end else begin
        unique case (state_ff)
          PPR_RX_IDLE: begin
            state_ff <= PPR_RX_IDLE;
          end
          PPR_RX_HEX: begin
            if (!is_hex) begin
              state_ff <= PPR_RX_IDLE;
            end else if (nib_cnt_ff == `PPR_QUERY_HEX - 4'd1) begin
              state_ff <= PPR_RX_CR;
            end
          end
          PPR_RX_CR: begin
            state_ff <= (i_rx_char == `PPR_CH_CR) ? PPR_RX_LF
                                                  : PPR_RX_IDLE;
          end
          PPR_RX_LF: begin
            state_ff <= PPR_RX_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // field gathering and lrc sum
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      nib_cnt_ff <= 4'h0;
      hi_nib_ff <= 4'h0;
      bytes_ff <= 56'h0;
      sum_ff <= 8'h00;
      char_cnt_ff <= 5'd0;
    end else if (i_clk_en && i_rx_valid) begin
      if (is_colon) begin
        nib_cnt_ff <= 4'h0;
        sum_ff <= 8'h00;
        char_cnt_ff <= 5'd1;
      end else if (state_ff != PPR_RX_IDLE) begin
        char_cnt_ff <= char_cnt_ff + 5'd1;
        if (state_ff == PPR_RX_HEX && is_hex) begin
          nib_cnt_ff <= nib_cnt_ff + 4'd1;
          if (!nib_cnt_ff[0]) begin
            hi_nib_ff <= hex_val;
          end else begin
            bytes_ff <= {bytes_ff[47:0], new_byte};
            if (nib_cnt_ff != `PPR_QUERY_HEX - 4'd1) begin
              sum_ff <= sum_ff + new_byte;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // served and dropped events
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      served_ff <= 1'b0;
      dropped_ff <= 1'b0;
    end else if (i_clk_en) begin
      served_ff <= frame_end && query_ok;
      dropped_ff <= i_rx_valid && state_ff != PPR_RX_IDLE &&
                    !(frame_end && query_ok) &&
                    (is_colon || frame_end ||
                     (state_ff == PPR_RX_HEX && !is_hex) ||
                     (state_ff == PPR_RX_CR && i_rx_char != `PPR_CH_CR) ||
                     state_ff == PPR_RX_LF);
    end
  end

  // ----------------------------------------------------------------------
  // register readout
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      value_ff <= 16'h0000;
    end else if (i_clk_en && frame_end && query_ok) begin
      if (f_start == `PPR_REG_ALARM_PROG) begin
        value_ff <= i_alarm_active ? i_alarm_program
                                   : `PPR_ALARM_IDLE;
      end else begin
        value_ff <= i_press_status;
      end
    end
  end

  ppr_reply_tx u_reply_tx (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_start(served_ff),
    .i_slave_addr(own_addr),
    .i_value(value_ff),
    .i_tx_ready(i_tx_ready),
    .o_tx_valid(o_tx_valid),
    .o_tx_char(o_tx_char),
    .o_busy(tx_busy)
  );

  assign o_reply_busy = tx_busy;
  assign o_query_served = served_ff;
  assign o_query_dropped = dropped_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_own_addr: assert property (
    $rose(served_ff) |-> $past(f_addr) == $past(own_addr))
    else $error("reply to foreign address");
  chk_func_read: assert property (
    $rose(served_ff) |-> $past(f_func) == `PPR_FUNC_READ &&
      $past(f_count) == `PPR_REG_COUNT_ONE)
    else $error("reply to unsupported function or count");
  chk_alarm_idle: assert property (
    $rose(served_ff) && $past(f_start) == `PPR_REG_ALARM_PROG &&
    !$past(i_alarm_active) |-> value_ff == `PPR_ALARM_IDLE)
    else $error("alarm program not zero without alarm");
  chk_status_value: assert property (
    $rose(served_ff) && $past(f_start) == `PPR_REG_PRESS_STAT |->
      value_ff == $past(i_press_status))
    else $error("status readout does not match");
  chk_query_length: assert property (
    $rose(served_ff) |-> $past(char_cnt_ff) == `PPR_QUERY_CHARS - 5'd1)
    else $error("served query is not seventeen characters");
  chk_lrc_good: assert property (
    $rose(served_ff) |-> $past(lrc_sum) == 8'h00)
    else $error("served query has bad lrc");
  chk_reply_cause: assert property (
    $rose(tx_busy) |-> $past(served_ff))
    else $error("reply started without a served query");

  cov_alarm_read: cover property (
    $rose(served_ff) && $past(f_start) == `PPR_REG_ALARM_PROG);
  cov_status_read: cover property (
    $rose(served_ff) && $past(f_start) == `PPR_REG_PRESS_STAT);
  cov_dropped: cover property ($rose(dropped_ff));
endmodule : ppr_modbus_reader

// file: src/ppr_pkg.sv
package ppr_pkg;

  typedef logic [7:0] ppr_char_t;
  typedef logic [7:0] ppr_byte_t;
  typedef logic [15:0] ppr_reg_t;

  typedef enum logic [1:0] {
    PPR_RX_IDLE,
    PPR_RX_HEX,
    PPR_RX_CR,
    PPR_RX_LF
  } ppr_rx_state_e;

  function automatic logic ppr_hex_valid(input ppr_char_t c);
    ppr_hex_valid = (c >= 8'h30 && c <= 8'h39) ||
                    (c >= 8'h41 && c <= 8'h46) ||
                    (c >= 8'h61 && c <= 8'h66);
  endfunction : ppr_hex_valid

  function automatic logic [3:0] ppr_hex_val(input ppr_char_t c);
    ppr_char_t t;
    t = 8'h00;
    if (c <= 8'h39) begin
      t = c - 8'h30;
    end else if (c <= 8'h46) begin
      t = c - 8'h37;
    end else begin
      t = c - 8'h57;
    end
    ppr_hex_val = t[3:0];
  endfunction : ppr_hex_val

  function automatic ppr_char_t ppr_hex_char(input logic [3:0] n);
    if (n < 4'ha) begin
      ppr_hex_char = {4'h3, n};
    end else begin
      ppr_hex_char = 8'h37 + {4'h0, n};
    end
  endfunction : ppr_hex_char

endpackage : ppr_pkg

// file: src/ppr_reply_tx.sv
`timescale 1ns/1ps
module ppr_reply_tx (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire ppr_pkg::ppr_byte_t i_slave_addr,
  input wire ppr_pkg::ppr_reg_t i_value,
  input wire logic i_tx_ready,
  output logic o_tx_valid,
  output ppr_pkg::ppr_char_t o_tx_char,
  output logic o_busy
);
  import ppr_pkg::*;
  `include "ppr_defines.svh"

  localparam ppr_byte_t BYTE_COUNT = `PPR_BYTE_COUNT_ONE;

  logic busy_ff;
  logic valid_ff;
  ppr_char_t char_ff;
  logic [3:0] idx_ff;
  logic [47:0] shreg_ff;
  ppr_byte_t nxt_lrc;
  logic advance;

  // ----------------------------------------------------------------------
  // reply framing
  // ----------------------------------------------------------------------
  assign nxt_lrc = 8'h00 - (i_slave_addr + `PPR_FUNC_READ + BYTE_COUNT +
                   i_value[15:8] + i_value[7:0]);
  assign advance = valid_ff && i_tx_ready;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      busy_ff <= 1'b0;
      valid_ff <= 1'b0;
      idx_ff <= 4'h0;
      char_ff <= 8'h00;
      shreg_ff <= 48'h0;
    end else if (i_clk_en) begin
      if (!busy_ff && i_start) begin
        busy_ff <= 1'b1;
        valid_ff <= 1'b1;
        idx_ff <= 4'h0;
        char_ff <= `PPR_CH_COLON;
        shreg_ff <= {i_slave_addr, `PPR_FUNC_READ, BYTE_COUNT, i_value,
                     nxt_lrc};
      end else if (advance) begin
        if (idx_ff == `PPR_RESP_CHARS - 4'd1) begin
          busy_ff <= 1'b0;
          valid_ff <= 1'b0;
          idx_ff <= 4'h0;
        end else begin
          idx_ff <= idx_ff + 4'd1;
          if (idx_ff < `PPR_RESP_HEX) begin
            char_ff <= ppr_hex_char(shreg_ff[47:44]);
            shreg_ff <= {shreg_ff[43:0], 4'h0};
          end else if (idx_ff == `PPR_RESP_HEX) begin
            char_ff <= `PPR_CH_CR;
          end else begin
            char_ff <= `PPR_CH_LF;
          end
        end
      end
    end
  end

  assign o_tx_valid = valid_ff;
  assign o_tx_char = char_ff;
  assign o_busy = busy_ff;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_frame_open: assert property (
    $rose(busy_ff) |-> char_ff == `PPR_CH_COLON)
    else $error("reply does not open with a colon");
  chk_resp_length: assert property (
    $fell(busy_ff) |-> $past(idx_ff) == `PPR_RESP_CHARS - 4'd1)
    else $error("reply length is not fifteen characters");
  chk_byte_count: assert property (
    valid_ff && (idx_ff == 4'd5 || idx_ff == 4'd6) |->
      char_ff == ppr_hex_char(idx_ff[0] ? BYTE_COUNT[7:4]
                                        : BYTE_COUNT[3:0]))
    else $error("byte count field is wrong");
  chk_hex_body: assert property (
    valid_ff && idx_ff >= 4'd1 && idx_ff <= `PPR_RESP_HEX |->
      ppr_hex_valid(char_ff))
    else $error("reply body character is not hex");
  chk_trailer_lf: assert property (
    valid_ff && idx_ff == `PPR_RESP_CHARS - 4'd1 |-> char_ff == `PPR_CH_LF)
    else $error("reply does not end with line feed");

  cov_reply_done: cover property ($fell(busy_ff));
endmodule : ppr_reply_tx

// file: verif/ppr_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// serial master: sends queries, collects reply characters
// ----------------------------------------------------------------------
module ppr_master_model (
  input wire logic i_sys_clk,
  input wire logic i_tx_valid,
  input wire ppr_pkg::ppr_char_t i_tx_char,
  output logic o_rx_valid,
  output ppr_pkg::ppr_char_t o_rx_char,
  output logic o_tx_ready
);
  import ppr_pkg::*;
  logic slow = 1'b0;
  ppr_char_t rxq[$];

  initial begin
    o_rx_valid = 1'b0;
    o_rx_char = 8'h00;
    o_tx_ready = 1'b1;
  end

  // sink stalls every other cycle when slow is set
  always @(negedge i_sys_clk) begin
    o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  end

  always @(posedge i_sys_clk) begin
    if (i_tx_valid && o_tx_ready) begin
      rxq.push_back(i_tx_char);
    end
  end

  function automatic ppr_char_t hexc(input logic [3:0] n);
    return (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
  endfunction : hexc

  task automatic put(input ppr_char_t c);
    @(negedge i_sys_clk);
    o_rx_valid = 1'b1;
    o_rx_char = c;
  endtask : put

  task automatic put_byte(input ppr_byte_t b);
    put(hexc(b[7:4]));
    put(hexc(b[3:0]));
  endtask : put_byte

  // header, six bytes, check field and trailer: 17 characters
  task automatic send_query(input ppr_byte_t a, input ppr_reg_t s,
                            input ppr_reg_t c, input ppr_byte_t flip);
    ppr_byte_t b[6];
    ppr_byte_t sum;
    b = '{a, 8'h03, s[15:8], s[7:0], c[15:8], c[7:0]};
    sum = 8'h00;
    put(8'h3a);
    foreach (b[i]) begin
      sum = sum + b[i];
      put_byte(b[i]);
    end
    put_byte((8'h00 - sum) ^ flip);
    put(8'h0d);
    put(8'h0a);
    @(negedge i_sys_clk);
    o_rx_valid = 1'b0;
    o_rx_char = ~o_rx_char;
  endtask : send_query
endmodule : ppr_master_model

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ppr_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [3:0] i_axis_number = 4'h0;
  logic i_alarm_active = 1'b0;
  ppr_reg_t i_alarm_program = 16'h0000;
  ppr_reg_t i_press_status = 16'h0000;
  logic rx_valid;
  logic tx_ready;
  logic o_tx_valid;
  logic o_reply_busy;
  logic o_query_served;
  logic o_query_dropped;
  ppr_char_t rx_char;
  ppr_char_t o_tx_char;
  int err_total = 0;
  int checks = 0;
  int drop_cnt = 0;
  int serve_cnt = 0;

  // one-cycle event pulses counted on the edge that samples them
  always @(posedge i_sys_clk) begin
    if (o_query_dropped === 1'b1) begin
      drop_cnt++;
    end
    if (o_query_served === 1'b1) begin
      serve_cnt++;
    end
  end

  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  ppr_modbus_reader u_ppr_modbus_reader (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(1'b1),
    .i_axis_number(i_axis_number),
    .i_rx_valid(rx_valid),
    .i_rx_char(rx_char),
    .i_tx_ready(tx_ready),
    .o_tx_valid(o_tx_valid),
    .o_tx_char(o_tx_char),
    .i_alarm_active(i_alarm_active),
    .i_alarm_program(i_alarm_program),
    .i_press_status(i_press_status),
    .o_reply_busy(o_reply_busy),
    .o_query_served(o_query_served),
    .o_query_dropped(o_query_dropped)
  );

  ppr_master_model u_ppr_master_model (
    .i_sys_clk(i_sys_clk),
    .i_tx_valid(o_tx_valid),
    .i_tx_char(o_tx_char),
    .o_rx_valid(rx_valid),
    .o_rx_char(rx_char),
    .o_tx_ready(tx_ready)
  );

  // ----------------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  function automatic ppr_char_t hx(input logic [3:0] n);
    return (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
  endfunction : hx

  // ----------------------------------------------------------------------
  // shared transfers
  // ----------------------------------------------------------------------
  task automatic run_read(input ppr_byte_t a, input ppr_reg_t s,
                          input ppr_reg_t v);
    ppr_char_t e[15];
    ppr_byte_t l;
    int n;
    int s0;
    l = 8'h00 - (a + 8'h05 + v[15:8] + v[7:0]);
    s0 = serve_cnt;
    e = '{8'h3a, hx(a[7:4]), hx(a[3:0]), 8'h30, 8'h33, 8'h30, 8'h32,
          hx(v[15:12]), hx(v[11:8]), hx(v[7:4]), hx(v[3:0]),
          hx(l[7:4]), hx(l[3:0]), 8'h0d, 8'h0a};
    n = 0;
    u_ppr_master_model.rxq.delete();
    u_ppr_master_model.send_query(a, s, 16'h0001, 8'h00);
    while (u_ppr_master_model.rxq.size() < 15 || o_reply_busy) begin
      @(negedge i_sys_clk);
      n++;
      if (n > 200) begin
        err_total++;
        $display("[ERR] %0t reply timeout", $time);
        print_verdict();
      end
    end
    cmp8(8'(u_ppr_master_model.rxq.size()), 8'd15);
    foreach (e[i]) cmp8(u_ppr_master_model.rxq[i], e[i]);
    cmp8({7'h00, o_tx_valid}, 8'h00);
    cmp8(8'(serve_cnt - s0), 8'd1);
  endtask : run_read

  task automatic expect_drop(input ppr_byte_t a, input ppr_reg_t s,
                             input ppr_reg_t c, input ppr_byte_t flip);
    int d0;
    int s0;
    d0 = drop_cnt;
    s0 = serve_cnt;
    u_ppr_master_model.rxq.delete();
    u_ppr_master_model.send_query(a, s, c, flip);
    repeat (30) @(negedge i_sys_clk);
    cmp8(8'(drop_cnt - d0), 8'd1);
    cmp8(8'(serve_cnt - s0), 8'd0);
    cmp8(8'(u_ppr_master_model.rxq.size()), 8'h00);
  endtask : expect_drop

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_alarm();
    i_alarm_active = 1'b1;
    i_alarm_program = 16'h0005;
    run_read(8'h01, 16'h9023, 16'h0005);
  endtask : s_alarm

  task automatic s_idle();
    i_alarm_active = 1'b0;
    i_alarm_program = 16'h1234;
    run_read(8'h01, 16'h9023, 16'h0000);
  endtask : s_idle

  task automatic s_status_slow();
    i_press_status = 16'h0102;
    u_ppr_master_model.slow = 1'b1;
    run_read(8'h01, 16'h9024, 16'h0102);
    u_ppr_master_model.slow = 1'b0;
  endtask : s_status_slow

  task automatic s_axis_top();
    i_axis_number = 4'hf;
    i_press_status = 16'habcd;
    repeat (4) @(negedge i_sys_clk);
    run_read(8'h10, 16'h9024, 16'habcd);
  endtask : s_axis_top

  task automatic s_drops();
    expect_drop(8'h01, 16'h9024, 16'h0001, 8'h00);
    expect_drop(8'h10, 16'h9024, 16'h0001, 8'h01);
    expect_drop(8'h10, 16'h9025, 16'h0001, 8'h00);
    expect_drop(8'h10, 16'h9023, 16'h0002, 8'h00);
  endtask : s_drops

  initial begin
    repeat (12) @(negedge i_sys_clk);
    i_reset = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    s_alarm();
    s_idle();
    s_status_slow();
    s_axis_top();
    s_drops();
    print_verdict();
  end
endmodule : testbench
